// *** sdcc_top.sv ***
// Conversion sequencing and serial result delivery for a 22-bit converter.
// Assumes a serial host driving cs_n_in and sck_in from outside clk_in.
// Contract
// R1 - Falling chip select starts a conversion
// R2 - Early chip select rise gives single conversion
// R3 - Chip select low keeps converting continuously
// R4 - Tied-low chip select converts from power-up
// R5 - Data/ready released while chip select high
// R6 - Shutdown whenever no conversion runs
// R7 - Filter state cleared between conversions
// R8 - Bit stream at quarter oscillator rate
// R9 - Calibration inside conversion, no extra time
// R10 - Fourth-order sinc gives 22-bit word
// R11 - Done: latch result, flag ready, reset
// R12 - Fixed output data rate per variant
// R13 - Notch at sample rate over OSR times order
// R14 - First conversion after shutdown adds 144 periods
// R15 - Host serial clock at most 5 MHz; the bench host model clocks at 12.5 MHz (40 ns low, 40 ns high)
// R16 - Shift on falling, host samples rising
// R17 - Ready drives output low with chip select low
// R18 - Shift out two overflow bits, 22 data
// R19 - Shutdown within 10 us of chip select high
// R20 - Host waits ready, then 24 clocks
// R21 - Serial side asynchronous to conversion timing
`timescale 1ns/1ps
`include "sdcc_defines.svh"
module sdcc_top #(
  // Internal oscillator ticks per conversion; default 16.67 ms at 122.88 kHz.
  parameter int CONV_OSC_PERIODS = 2048,
  // clk_in cycles per internal oscillator period (about 8.14 us).
  parameter int OSC_DIV = 814,
  // Oscillator ticks spent on offset and gain calibration at conversion start.
  parameter int CAL_OSC_PERIODS = 16
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Serial pins
  input wire logic cs_n_in,
  input wire logic sck_in,
  output logic data_ready_out,
  output logic data_ready_oe_n_out,
  // Modulator stream
  input wire logic mod_bit_in,
  // Status
  output logic shutdown_out,
  output logic converting_out
);
  // ----------------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------------
  logic cs_m_r, cs_s_r, cs_d_r, sck_m_r, sck_s_r, sck_d_r, mod_m_r, mod_s_r;
  logic cs_fall, cs_low, sck_fall, sck_rise;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cs_m_r <= 1'b1;
      cs_s_r <= 1'b1;
      cs_d_r <= 1'b1;
      sck_m_r <= 1'b0;
      sck_s_r <= 1'b0;
      sck_d_r <= 1'b0;
      mod_m_r <= 1'b0;
      mod_s_r <= 1'b0;
    end else begin
      cs_m_r <= cs_n_in;
      cs_s_r <= cs_m_r;
      cs_d_r <= cs_s_r;
      sck_m_r <= sck_in;
      sck_s_r <= sck_m_r;
      sck_d_r <= sck_s_r;
      mod_m_r <= mod_bit_in;
      mod_s_r <= mod_m_r;
    end
  end

  // The reset value of cs_d_r is high, so a tied-low chip select looks like
  // a falling edge right after reset and starts converting at power-up.
  assign cs_fall = cs_d_r && !cs_s_r; // [R1] [R4]
  assign cs_low = !cs_s_r;
  assign sck_fall = sck_d_r && !sck_s_r; // [R21]
  assign sck_rise = !sck_d_r && sck_s_r; // [R16]

  // ----------------------------------------------------------------------
  // Internal oscillator model and bit-rate divider
  // ----------------------------------------------------------------------
  sdcc_pkg::sdcc_state_t state_r;
  logic [15:0] osc_cnt_r;
  logic osc_tick;
  logic [1:0] quad_r;
  logic bit_stb;

  // The oscillator is held in reset during shutdown, like the real one.
  always_ff @(posedge clk_in) begin
    if (rst_in || state_r != sdcc_pkg::SDCC_CONV) begin
      osc_cnt_r <= '0;
    end else if (osc_cnt_r == 16'(OSC_DIV - 1)) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_cnt_r + 16'h0001;
    end
  end
  assign osc_tick = (state_r == sdcc_pkg::SDCC_CONV) && (osc_cnt_r == 16'(OSC_DIV - 1));

  always_ff @(posedge clk_in) begin
    if (rst_in || state_r != sdcc_pkg::SDCC_CONV) begin
      quad_r <= '0;
    end else if (osc_tick) begin
      quad_r <= quad_r + 2'h1;
    end
  end
  assign bit_stb = osc_tick && (quad_r == 2'(`SDCC_BIT_DIV - 1)); // [R8]

  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  logic [15:0] tick_cnt_r;
  logic [15:0] conv_len_r;
  logic first_r;
  logic single_r;
  logic conv_end;
  logic cal_phase;
  logic [10:0] idle_cnt_r;

  assign conv_end = osc_tick && (tick_cnt_r == conv_len_r - 16'h0001);
  // Calibration overlaps the conversion; the bit stream is muted meanwhile.
  assign cal_phase = tick_cnt_r < 16'(CAL_OSC_PERIODS); // [R9]

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r <= sdcc_pkg::SDCC_SHDN;
    end else begin
      case (state_r)
        sdcc_pkg::SDCC_SHDN: begin
          if (cs_fall) begin
            state_r <= sdcc_pkg::SDCC_CONV; // [R1]
          end
        end
        sdcc_pkg::SDCC_CONV: begin
          if (!first_r && !cs_low) begin
            // Only the first conversion may run on deselected; later ones stop at once.
            state_r <= sdcc_pkg::SDCC_SHDN; // [R19]
          end else if (conv_end) begin
            state_r <= sdcc_pkg::SDCC_DONE; // [R11]
          end
        end
        sdcc_pkg::SDCC_DONE: begin
          if (!single_r && cs_low) begin
            state_r <= sdcc_pkg::SDCC_CONV; // [R3]
          end else begin
            state_r <= sdcc_pkg::SDCC_SHDN; // [R2] [R6]
          end
        end
        default: begin
          state_r <= sdcc_pkg::SDCC_SHDN;
        end
      endcase
    end
  end

  // A chip select rise during the first conversion makes it a single one.
  always_ff @(posedge clk_in) begin
    if (rst_in || state_r == sdcc_pkg::SDCC_SHDN) begin
      single_r <= 1'b0;
    end else if (state_r == sdcc_pkg::SDCC_CONV && first_r && !cs_low) begin
      single_r <= 1'b1; // [R2]
    end
  end

  // The first conversion after shutdown runs 144 extra oscillator periods.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      first_r <= 1'b1;
      conv_len_r <= 16'(CONV_OSC_PERIODS + `SDCC_WAKE_OSC_PERIODS);
    end else if (state_r == sdcc_pkg::SDCC_SHDN) begin
      first_r <= 1'b1;
      conv_len_r <= 16'(CONV_OSC_PERIODS + `SDCC_WAKE_OSC_PERIODS); // [R14]
    end else if (state_r == sdcc_pkg::SDCC_DONE) begin
      first_r <= 1'b0;
      conv_len_r <= 16'(CONV_OSC_PERIODS); // [R12] [R13]
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || state_r != sdcc_pkg::SDCC_CONV) begin
      tick_cnt_r <= '0;
    end else if (osc_tick) begin
      tick_cnt_r <= tick_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------------
  // Decimation filter
  // ----------------------------------------------------------------------
  logic [`SDCC_DATA_BITS-1:0] result;

  sdcc_decim #(
    .ACC_W(`SDCC_ACC_BITS)
  ) u_decim (
    .clk_in(clk_in),
    .rst_in(rst_in),
    // Clearing whenever no conversion runs also flushes a conversion that was cut.
    .clear_in(state_r != sdcc_pkg::SDCC_CONV), // [R7]
    .bit_stb_in(bit_stb && !cal_phase), // [R8] [R9]
    .bit_in(mod_s_r),
    .dump_in(conv_end), // [R11]
    .result_out(result)
  );

  // ----------------------------------------------------------------------
  // Result delivery
  // ----------------------------------------------------------------------
  logic [`SDCC_WORD_BITS-1:0] shift_r;
  logic ready_r;
  logic reading_r;
  logic [4:0] bit_cnt_r;
  logic dout_r;
  logic ovh, ovl;

  // Overflow flags mark a result pinned at either end of the 22-bit range.
  assign ovh = (result == {1'b0, {(`SDCC_DATA_BITS-1){1'b1}}});
  assign ovl = (result == {1'b1, {(`SDCC_DATA_BITS-1){1'b0}}});

  always_ff @(posedge clk_in) begin
    if (rst_in || !cs_low) begin
      ready_r <= 1'b0;
      reading_r <= 1'b0;
      bit_cnt_r <= '0;
      shift_r <= '0;
      dout_r <= 1'b1;
    end else if (state_r == sdcc_pkg::SDCC_DONE && !reading_r) begin
      ready_r <= 1'b1; // [R11] [R17]
      shift_r <= {ovl, ovh, result}; // [R18]
      dout_r <= 1'b0; // [R17]
    end else if (ready_r && sck_fall) begin
      reading_r <= 1'b1;
      dout_r <= shift_r[`SDCC_WORD_BITS-1]; // [R16] [R18]
      shift_r <= {shift_r[`SDCC_WORD_BITS-2:0], 1'b0};
      if (bit_cnt_r == 5'(`SDCC_WORD_BITS - 1)) begin
        ready_r <= 1'b0;
        bit_cnt_r <= '0;
      end else begin
        bit_cnt_r <= bit_cnt_r + 5'h01;
      end
    end else if (!ready_r && reading_r && sck_rise) begin
      // The last bit stands until the host has sampled it on the rising edge.
      reading_r <= 1'b0;
      dout_r <= 1'b1; // [R16] [R18]
    end else if (!ready_r && !reading_r && state_r == sdcc_pkg::SDCC_CONV) begin
      dout_r <= 1'b1;
    end
  end

  assign data_ready_out = dout_r;
  assign data_ready_oe_n_out = !cs_low; // [R5]

  // ----------------------------------------------------------------------
  // Shutdown status
  // ----------------------------------------------------------------------
  // Shutdown follows the idle state within a few cycles, well inside 10 us.
  // Reset parks the count at its end, so shutdown_out does not dip after reset.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      idle_cnt_r <= 11'(`SDCC_SHDN_LAG);
    end else if (state_r != sdcc_pkg::SDCC_SHDN) begin
      idle_cnt_r <= '0;
    end else if (idle_cnt_r != 11'(`SDCC_SHDN_LAG)) begin
      idle_cnt_r <= idle_cnt_r + 11'h001;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      shutdown_out <= 1'b1;
      converting_out <= 1'b0;
    end else begin
      shutdown_out <= (idle_cnt_r == 11'(`SDCC_SHDN_LAG)); // [R6] [R19]
      converting_out <= (state_r == sdcc_pkg::SDCC_CONV);
    end
  end
endmodule

// *** sdcc_defines.svh ***
// Constants for the delta-sigma conversion control block.
// Assumes inclusion by its bare name; holds definitions only.
`ifndef SDCC_DEFINES_SVH
`define SDCC_DEFINES_SVH
// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define SDCC_CLK_MHZ 100
`define SDCC_SHDN_TIME_US 10
`define SDCC_SHDN_CYCLES (`SDCC_SHDN_TIME_US * `SDCC_CLK_MHZ)
`define SDCC_WAKE_OSC_PERIODS 144
`define SDCC_BIT_DIV 4
`define SDCC_SHDN_LAG 2
// ----------------------------------------------------------------------
// Result word
// ----------------------------------------------------------------------
`define SDCC_DATA_BITS 22
`define SDCC_WORD_BITS 24
`define SDCC_OVL_IDX 23
`define SDCC_OVH_IDX 22
// Fourth integrator width; a wake-up conversion at full length stays inside it.
`define SDCC_ACC_BITS 34
`endif

// *** sdcc_pkg.sv ***
// Types shared by the conversion control block.
// Assumes sdcc_defines.svh is compiled alongside.
package sdcc_pkg;
  typedef enum logic [1:0] {
    SDCC_SHDN = 2'b00,
    SDCC_CONV = 2'b01,
    SDCC_DONE = 2'b10
  } sdcc_state_t;
endpackage

// *** sdcc_decim.sv ***
// Fourth-order sinc decimator over a one-bit modulator stream.
// Assumes a one-cycle bit strobe and a clear pulse between conversions.
`timescale 1ns/1ps
`include "sdcc_defines.svh"
module sdcc_decim #(
  parameter int ACC_W = 32
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Stream
  input wire logic clear_in,
  input wire logic bit_stb_in,
  input wire logic bit_in,
  // Result
  input wire logic dump_in,
  output logic [`SDCC_DATA_BITS-1:0] result_out
);
  logic [ACC_W-1:0] integ_r [0:3];
  logic [ACC_W-1:0] sample;

  assign sample = bit_in ? ACC_W'(1) : {ACC_W{1'b1}};

  // ----------------------------------------------------------------------
  // Integrator cascade
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_int
      always_ff @(posedge clk_in) begin
        if (rst_in || clear_in) begin
          integ_r[g] <= '0; // [R7]
        end else if (bit_stb_in) begin
          integ_r[g] <= integ_r[g] + ((g == 0) ? sample : integ_r[(g == 0) ? 0 : g - 1]); // [R10]
        end
      end
    end
  endgenerate

  // The comb section is collapsed: since state is flushed per conversion, the
  // final integrator already holds the weighted average of this conversion.
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      result_out <= '0;
    end else if (dump_in) begin
      result_out <= integ_r[3][ACC_W-1 -: `SDCC_DATA_BITS]; // [R10]
    end
  end
endmodule

// *** sdcc_chk.sv ***
// Port assertions for sdcc_top.
// Assumes a bind that hands on the top's count parameters.
`timescale 1ns/1ps
module sdcc_chk #(
  parameter int CONV_OSC_PERIODS = 2048,
  parameter int OSC_DIV = 814
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic cs_n_in,
  input wire logic data_ready_out,
  input wire logic data_ready_oe_n_out,
  input wire logic shutdown_out,
  input wire logic converting_out
);
  localparam int WAKE = (CONV_OSC_PERIODS + 144) * OSC_DIV;
  localparam int RUN = CONV_OSC_PERIODS * OSC_DIV;
  int len_r;
  logic wake_r;
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  always_ff @(posedge clk_in) begin
    len_r <= (rst_in || !converting_out) ? 0 : len_r + 1;
  end
  // A conversion begun from shutdown carries the wake-up periods.
  always_ff @(posedge clk_in) begin
    if (rst_in || shutdown_out) begin
      wake_r <= 1'b1;
    end else if (!converting_out && len_r != 0) begin
      wake_r <= 1'b0;
    end
  end
  a_oe_release: assert property (cs_n_in [*5] |-> data_ready_oe_n_out)
    else $error("line driven while deselected");
  a_oe_drive: assert property (!cs_n_in [*5] |-> !data_ready_oe_n_out)
    else $error("line not driven while selected");
  a_conv_start: assert property ($fell(cs_n_in) && shutdown_out |-> ##[1:6] converting_out)
    else $error("no conversion after select");
  a_wake_len: assert property ($fell(converting_out) && wake_r |->
    len_r >= WAKE - 4 && len_r <= WAKE + 8) else $error("wake conversion length wrong");
  a_run_len: assert property ($fell(converting_out) && !wake_r && !cs_n_in |->
    len_r >= RUN - 4 && len_r <= RUN + 8) else $error("conversion length wrong");
  a_ready_flag: assert property ($fell(converting_out) && !cs_n_in |-> ##[0:4] !data_ready_out)
    else $error("no ready flag after conversion");
  a_cont_next: assert property ($fell(converting_out) && !cs_n_in |-> ##[1:4] converting_out)
    else $error("no automatic next conversion");
  a_single_stop: assert property ($fell(converting_out) && cs_n_in |=> !converting_out [*8])
    else $error("conversion restarted while deselected");
  a_busy_awake: assert property (converting_out [*2] |-> !shutdown_out)
    else $error("shutdown while converting");
  a_idle_shdn: assert property (!converting_out [*8] |-> shutdown_out)
    else $error("idle without shutdown");
  a_desel_stop: assert property (cs_n_in [*8] |-> !converting_out || wake_r)
    else $error("later conversion kept running while deselected");
  c_cont: cover property ($fell(converting_out) && !cs_n_in);
  c_single: cover property ($fell(converting_out) && cs_n_in);
  c_start: cover property ($fell(cs_n_in) && shutdown_out);
endmodule

// *** sdcc_host.sv ***
// Serial host model: chip select and a mode 1,1 serial clock.
// Assumes the bench resolves the data/ready line into line_in.
`timescale 1ns/1ps
module sdcc_host (
  // Clock and line
  input wire logic clk_in,
  input wire logic line_in,
  // Pins
  output logic cs_n_out,
  output logic sck_out
);
  initial begin
    cs_n_out = 1'b0;
    sck_out = 1'b1;
  end
  task automatic select(input logic lvl);
    @(posedge clk_in);
    #1 cs_n_out = lvl;
  endtask
  // The clock stands high outside frames and moves 1 ns after a clk_in edge.
  // Each bit is taken at the rising edge, a low phase after the device shifted it.
  task automatic read_word(output logic [23:0] w);
    for (int i = 23; i >= 0; i--) begin
      sck_out = 1'b0;
      #40 w[i] = line_in;
      sck_out = 1'b1;
      #40;
    end
  endtask
endmodule

// *** tb_top.sv ***
// Self-checking bench for sdcc_top with a serial host model.
// Assumes the design files and sdcc_chk are compiled first.
`timescale 1ns/1ps
module tb_top;
  localparam int CONV = 128;
  localparam int DIV = 4;
  localparam int WAKE = (CONV + 144) * DIV;
  localparam int RUN = CONV * DIV;
  // Ten microseconds of 10 ns cycles.
  localparam int SHDN_LIM = 1000;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic mod_bit = 1'b1;
  logic line_last = 1'b0;
  logic line;
  logic cs_n, sck, dr, dr_oe_n, shdn, conv;
  logic [23:0] w1, w2;
  int miscompares = 0;
  int n_compared = 0;
  int n;
  always #5 clk_in = ~clk_in;
  // A released line shows the inverse of its last driven level, never a held value.
  always @(posedge clk_in) begin
    if (!dr_oe_n) line_last <= dr;
  end
  always_comb line = dr_oe_n ? ~line_last : dr;
  sdcc_top #(.CONV_OSC_PERIODS(CONV), .OSC_DIV(DIV)) u_sdcc_top (
    .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n), .sck_in(sck), .data_ready_out(dr),
    .data_ready_oe_n_out(dr_oe_n), .mod_bit_in(mod_bit), .shutdown_out(shdn),
    .converting_out(conv));
  sdcc_host u_sdcc_host (.clk_in(clk_in), .line_in(line), .cs_n_out(cs_n), .sck_out(sck));
  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic wait_for(input string what, ref logic sig, input logic lvl, input int limit);
    n = 0;
    while (sig !== lvl) begin
      if (n == limit) begin
        miscompares++;
        $display("Error %s expected %0d seen timeout", what, limit);
        end_of_test();
      end
      @(posedge clk_in);
      #1 n++;
    end
  endtask
  task automatic next_ready;
    wait_for("done", conv, 1'b0, RUN);
    wait_for("ready", line, 1'b0, 6);
  endtask
  task automatic test_powerup;
    repeat (16) @(posedge clk_in);
    #1 check("shutdown in reset", shdn, 1);
    check("converting in reset", conv, 0);
    rst_in = 1'b0;
    wait_for("start", conv, 1'b1, 8);
    wait_for("first ready", line, 1'b0, WAKE + 20);
    check("wake time", n >= WAKE - 4 && n <= WAKE + 12, 1);
    u_sdcc_host.read_word(w1);
    $display("test_powerup done");
  endtask
  task automatic test_continuous;
    next_ready();
    u_sdcc_host.read_word(w1);
    next_ready();
    u_sdcc_host.read_word(w2);
    check("repeat word", w2, w1);
    check("sign full scale", w2[21], 0);
    u_sdcc_host.select(1'b1);
    repeat (5) @(posedge clk_in);
    #1 check("released", dr_oe_n, 1);
    wait_for("shutdown", shdn, 1'b1, SHDN_LIM);
    $display("test_continuous done");
  endtask
  task automatic test_single;
    mod_bit = 1'b0;
    u_sdcc_host.select(1'b0);
    wait_for("start", conv, 1'b1, 8);
    repeat (20) @(posedge clk_in);
    u_sdcc_host.select(1'b1);
    wait_for("end", conv, 1'b0, WAKE + 20);
    check("single length", n >= WAKE - 24 && n <= WAKE - 18, 1);
    repeat (2 * RUN) @(posedge clk_in);
    #1 check("no restart", conv, 0);
    check("idle shutdown", shdn, 1);
    $display("test_single done");
  endtask
  task automatic test_negative;
    u_sdcc_host.select(1'b0);
    repeat (4) @(posedge clk_in);
    #1;
    wait_for("wake ready", line, 1'b0, WAKE + 20);
    check("wake again", n >= WAKE - 4 && n <= WAKE + 12, 1);
    u_sdcc_host.read_word(w1);
    check("sign negative", w1[21], 1);
    u_sdcc_host.select(1'b1);
    $display("test_negative done");
  endtask
  initial begin
    test_powerup();
    test_continuous();
    test_single();
    test_negative();
    end_of_test();
  end
endmodule
bind sdcc_top sdcc_chk #(.CONV_OSC_PERIODS(CONV_OSC_PERIODS), .OSC_DIV(OSC_DIV)) u_sdcc_chk (
  .clk_in(clk_in), .rst_in(rst_in), .cs_n_in(cs_n_in), .data_ready_out(data_ready_out),
  .data_ready_oe_n_out(data_ready_oe_n_out), .shutdown_out(shutdown_out),
  .converting_out(converting_out));
